// file: mmt_top.sv
// Purpose: General-purpose and measurement timers with request flags
// Assumes: Control bits arrive as plain ports on mclk_in
// Notes: Pin inputs are synchronised through three flops
`timescale 1ns/1ps
`default_nettype none
module mmt_top
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [1:0] a_mode_in,
  input wire logic a_start_in,
  input wire logic a_event_up_in,
  input wire logic a_wr_in,
  input wire logic [15:0] a_wdata_in,
  input wire logic a_event_pin_in,
  input wire logic a_irq_clr_in,
  input wire logic a_irq_ack_in,
  output logic [15:0] a_count_out,
  output logic general_timer_output_pin_out,
  output logic a_irq_flag_out,
  input wire logic [1:0] b_mode_in,
  input wire logic b_start_in,
  input wire logic b_meas_sel_in,
  input wire logic b_wr_in,
  input wire logic [15:0] b_wdata_in,
  input wire logic b_edge_pin_in,
  input wire logic b_irq_clr_in,
  input wire logic b_irq_ack_in,
  output logic [15:0] b_count_out,
  output logic [15:0] b_reload_out,
  output logic b_irq_flag_out
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  wire rst_n = rst_sync_r[1];
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] aev_r;
  logic [2:0] bev_r;
  logic aev_lvl_r;
  logic bev_lvl_r;
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aev_r <= 3'h0;
      bev_r <= 3'h0;
      aev_lvl_r <= 1'b0;
      bev_lvl_r <= 1'b0;
    end
    else
    begin
      aev_r <= {aev_r[1:0], a_event_pin_in};
      bev_r <= {bev_r[1:0], b_edge_pin_in};
      if (aev_r[1] == aev_r[2])
        aev_lvl_r <= aev_r[2];
      if (bev_r[1] == bev_r[2])
        bev_lvl_r <= bev_r[2];
    end
  end
  logic aev_d_r;
  logic bev_d_r;
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aev_d_r <= 1'b0;
      bev_d_r <= 1'b0;
    end
    else
    begin
      aev_d_r <= aev_lvl_r;
      bev_d_r <= bev_lvl_r;
    end
  end
  wire a_evt = aev_lvl_r && !aev_d_r;
  wire b_edge = bev_lvl_r && !bev_d_r;

  // ----------------------------------------
  // General timer counter
  // ----------------------------------------
  logic [15:0] a_cnt_r;
  logic [15:0] a_rld_r;
  logic a_out_r;
  logic a_start_d_r;
  logic [1:0] a_mode_d_r;
  logic a_first_r;
  logic a_irq_r;
  wire a_tick = (a_mode_in == mmt_pkg::MMT_EVENT) ? a_evt : 1'b1;
  wire a_is_evt = (a_mode_in == mmt_pkg::MMT_EVENT);
  wire a_up = a_is_evt && a_event_up_in;
  wire a_under = a_cnt_r == mmt_pkg::ALL_ZEROS;
  wire a_over = a_cnt_r == mmt_pkg::ALL_ONES;
  wire a_wrap = a_up ? a_over : a_under;
  wire a_reload = a_start_in && a_tick && a_wrap;
  wire a_stop = a_start_d_r && !a_start_in;
  wire a_plain = (a_mode_d_r == mmt_pkg::MMT_TIMER) || (a_mode_d_r == mmt_pkg::MMT_EVENT);
  wire a_to_os = (a_mode_in == mmt_pkg::MMT_ONESHOT) && (a_first_r || (a_plain && a_mode_d_r != a_mode_in));
  wire a_to_pwm = (a_mode_in == mmt_pkg::MMT_PWM) && (a_first_r || (a_plain && a_mode_d_r != a_mode_in));
  wire a_os = a_mode_in == mmt_pkg::MMT_ONESHOT;
  wire a_pwm = a_mode_in == mmt_pkg::MMT_PWM;
  wire a_os_stop = a_os && a_stop; // see RULE_06
  wire a_pwm_stop = a_pwm && a_stop && a_out_r; // see RULE_10
  wire a_os_done = a_os && a_start_in && a_tick && a_under;
  wire a_set = a_to_os || a_to_pwm || a_os_stop || a_pwm_stop || a_os_done || (a_reload && !a_os); // see RULE_07 RULE_08

  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_cnt_r <= 16'h0000;
      a_rld_r <= 16'h0000;
      a_out_r <= 1'b0;
      a_start_d_r <= 1'b0;
      a_mode_d_r <= 2'h0;
      a_first_r <= 1'b1;
    end
    else
    begin
      a_start_d_r <= a_start_in;
      a_mode_d_r <= a_mode_in;
      a_first_r <= 1'b0;
      // A write while counting only changes the reload value and does not freeze the count
      if (a_wr_in)
        a_rld_r <= a_wdata_in;
      if (a_wr_in && !a_start_in)
        a_cnt_r <= a_wdata_in; // see RULE_04
      else if (a_os_stop)
      begin
        a_cnt_r <= a_rld_r; // see RULE_06
        a_out_r <= 1'b0; // see RULE_06
      end
      else if (a_pwm_stop)
        a_out_r <= 1'b0; // see RULE_10
      else if (a_start_in && a_tick)
      begin
        if (a_wrap)
          a_cnt_r <= a_up ? mmt_pkg::ALL_ZEROS : a_rld_r;
        else
          a_cnt_r <= a_up ? a_cnt_r + mmt_pkg::ONE : a_cnt_r - mmt_pkg::ONE;
        if (a_os)
          a_out_r <= !a_under;
        else if (a_pwm && a_under)
          a_out_r <= !a_out_r;
      end
    end
  end

  // Reload instant shows the wrap value, not the reloaded one; see RULE_01 RULE_02 RULE_03
  assign a_count_out = (a_reload && !a_os && !a_pwm) ? (a_up ? mmt_pkg::ALL_ZEROS : mmt_pkg::ALL_ONES) : a_cnt_r;
  assign general_timer_output_pin_out = a_out_r;

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  // Software rewrites the value after a free-run stop; no hardware help (see RULE_05)
  // Spurious mode-change requests are left for software to clear (see RULE_09)
  logic b_set;
  logic b_irq_r;
  always_ff @(posedge mclk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_irq_r <= 1'b0;
      b_irq_r <= 1'b0;
    end
    else
    begin
      // Set beats clear in the same cycle; see RULE_14
      a_irq_r <= a_set || (a_irq_r && !a_irq_clr_in && !a_irq_ack_in);
      b_irq_r <= b_set || (b_irq_r && !b_irq_clr_in && !b_irq_ack_in);
    end
  end
  assign a_irq_flag_out = a_irq_r;
  assign b_irq_flag_out = b_irq_r;

  // ----------------------------------------
  // Measurement timer
  // ----------------------------------------
  logic b_irq_evt;
  logic [15:0] b_cnt;
  wire b_tick = (b_mode_in == mmt_pkg::MMT_BEVENT) ? b_edge : 1'b1;
  mmt_btimer u_bt
  (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .mode_in(b_mode_in),
    .start_in(b_start_in),
    .meas_sel_in(b_meas_sel_in),
    .tick_in(b_tick),
    .edge_in(b_edge),
    .wr_in(b_wr_in),
    .wdata_in(b_wdata_in),
    .count_out(b_cnt),
    .reload_out(b_reload_out),
    .irq_set_out(b_irq_evt)
  );
  assign b_count_out = b_cnt;
  assign b_set = b_irq_evt;
endmodule
`default_nettype wire

// file: mmt_pkg.sv
// Purpose: Shared constants for the multi-mode timer block
// Assumes: One 100 MHz clock, registers reached as plain ports
// Notes:
// Notes on behaviour
// RULE_01: A running general timer's count read returns the live counter value.
// RULE_02: In timer mode a read at the reload instant returns all ones.
// RULE_03: Event counter reload read gives all ones on underflow, zeros on overflow.
// RULE_04: A value written while halted reads back correctly before counting.
// RULE_05: Software rewrites the value after stopping a free-running event counter.
// RULE_06: One-shot stop reloads counter, drives output low, sets request flag.
// RULE_07: Selecting one-shot after reset or from timer/event mode sets request flag.
// RULE_08: Selecting PWM after reset or from timer/event mode sets request flag.
// RULE_09: Software clears the request flag after those mode selections.
// RULE_10: PWM stop halts count; a high output goes low and sets the flag.
// RULE_11: Measurement timer reads live, all ones at reload, written value when halted.
// RULE_12: Changing measurement selection after start sets the request flag.
// RULE_13: First measured edge loads an undefined value and raises no request.
// RULE_14: The request flag stays set until software clears it or it is accepted.
package mmt_pkg;
  localparam int CW = 16;
  localparam logic [15:0] ALL_ONES = 16'hFFFF;
  localparam logic [15:0] ALL_ZEROS = 16'h0000;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [15:0] UNDEF_VAL = 16'hFFFF;
  typedef enum logic [1:0]
  {
    MMT_TIMER = 2'h0,
    MMT_EVENT = 2'h1,
    MMT_ONESHOT = 2'h2,
    MMT_PWM = 2'h3
  } mmt_amode_e;
  typedef enum logic [1:0]
  {
    MMT_BTIMER = 2'h0,
    MMT_BEVENT = 2'h1,
    MMT_BMEAS = 2'h2,
    MMT_BRSVD = 2'h3
  } mmt_bmode_e;
endpackage

// file: mmt_btimer.sv
// Purpose: Measurement-class 16-bit timer
// Assumes: Edges arrive as same-clock one-cycle pulses
// Notes: Measurement counts up from zero and captures on edges
`timescale 1ns/1ps
`default_nettype none
module mmt_btimer
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [1:0] mode_in,
  input wire logic start_in,
  input wire logic meas_sel_in,
  input wire logic tick_in,
  input wire logic edge_in,
  input wire logic wr_in,
  input wire logic [15:0] wdata_in,
  output logic [15:0] count_out,
  output logic [15:0] reload_out,
  output logic irq_set_out
);
  logic [15:0] cnt_r;
  logic [15:0] rld_r;
  logic first_r;
  logic sel_r;
  logic started_r;
  logic irq_r;
  wire meas = (mode_in == mmt_pkg::MMT_BMEAS);
  wire reload_now = start_in && !meas && tick_in && (cnt_r == mmt_pkg::ALL_ZEROS);
  wire sel_chg = meas && started_r && (meas_sel_in != sel_r);
  wire cap = meas && start_in && edge_in;

  // ----------------------------------------
  // Counter and capture
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 16'h0000;
      rld_r <= 16'h0000;
      first_r <= 1'b1;
      sel_r <= 1'b0;
      started_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      sel_r <= meas_sel_in;
      started_r <= start_in;
      // Plain-mode reload request comes from the internal counter, not the all-ones read value
      irq_r <= reload_now;
      if (!start_in)
        first_r <= 1'b1;
      // A write while counting only changes the reload value and does not freeze the count
      if (wr_in)
        rld_r <= wdata_in;
      if (wr_in && !start_in)
        cnt_r <= wdata_in; // see RULE_11
      else if (meas)
      begin
        if (cap)
        begin
          // First edge: counter origin is unknown, so capture is junk and silent
          rld_r <= first_r ? mmt_pkg::UNDEF_VAL : cnt_r; // see RULE_13
          irq_r <= !first_r; // see RULE_13
          first_r <= 1'b0;
          cnt_r <= mmt_pkg::ALL_ZEROS;
        end
        else if (start_in && tick_in)
          cnt_r <= cnt_r + mmt_pkg::ONE;
      end
      else if (start_in && tick_in)
        cnt_r <= (cnt_r == mmt_pkg::ALL_ZEROS) ? rld_r : cnt_r - mmt_pkg::ONE;
      if (sel_chg)
        irq_r <= 1'b1; // see RULE_12
    end
  end

  assign count_out = reload_now ? mmt_pkg::ALL_ONES : cnt_r; // see RULE_11
  assign reload_out = rld_r;
  assign irq_set_out = irq_r;
endmodule
`default_nettype wire

// file: mmt_chk.sv
// Purpose: Port-level assertions for mmt_top
// Assumes: One clock domain, reset active low
// Notes: Flag reactions are allowed up to three cycles
`timescale 1ns/1ps
`default_nettype none
module mmt_chk
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [1:0] a_mode_in,
  input wire logic a_start_in,
  input wire logic a_wr_in,
  input wire logic [15:0] a_wdata_in,
  input wire logic a_irq_clr_in,
  input wire logic a_irq_ack_in,
  input wire logic [15:0] a_count_out,
  input wire logic general_timer_output_pin_out,
  input wire logic a_irq_flag_out,
  input wire logic [1:0] b_mode_in,
  input wire logic b_start_in,
  input wire logic b_meas_sel_in,
  input wire logic b_wr_in,
  input wire logic [15:0] b_wdata_in,
  input wire logic b_irq_clr_in,
  input wire logic b_irq_ack_in,
  input wire logic [15:0] b_count_out,
  input wire logic b_irq_flag_out
);
  // --------
  // Checks
  // --------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  AST_A_STICKY: assert property (a_irq_flag_out && !a_irq_clr_in && !a_irq_ack_in |=> a_irq_flag_out)
    else $error("timer a flag dropped");
  AST_B_STICKY: assert property (b_irq_flag_out && !b_irq_clr_in && !b_irq_ack_in |=> b_irq_flag_out)
    else $error("timer b flag dropped");
  AST_A_HALT_READ: assert property (a_wr_in && !a_start_in |=> a_count_out == $past(a_wdata_in))
    else $error("timer a halted write not read back");
  AST_B_HALT_READ: assert property (b_wr_in && !b_start_in |=> b_count_out == $past(b_wdata_in))
    else $error("timer b halted write not read back");
  AST_ONESHOT_STOP: assert property (a_mode_in == 2'h2 && $stable(a_mode_in) && $fell(a_start_in)
    |-> ##[1:3] (!general_timer_output_pin_out && a_irq_flag_out)) else $error("one-shot stop wrong");
  AST_PWM_STOP_HIGH: assert property (a_mode_in == 2'h3 && $fell(a_start_in) && general_timer_output_pin_out
    |-> ##[1:3] (!general_timer_output_pin_out && a_irq_flag_out)) else $error("pwm stop from high wrong");
  AST_PWM_STOP_LOW: assert property (a_mode_in == 2'h3 && $fell(a_start_in) && !general_timer_output_pin_out
    |=> !general_timer_output_pin_out [*3]) else $error("pwm stop from low changed output");
  AST_TO_ONESHOT: assert property ($changed(a_mode_in) && a_mode_in == 2'h2 && !$past(a_mode_in[1])
    |-> ##[1:3] a_irq_flag_out) else $error("one-shot select did not set flag");
  AST_TO_PWM: assert property ($changed(a_mode_in) && a_mode_in == 2'h3 && !$past(a_mode_in[1])
    |-> ##[1:3] a_irq_flag_out) else $error("pwm select did not set flag");
  AST_MEAS_SEL: assert property (b_mode_in == 2'h2 && b_start_in && $past(b_start_in) && $changed(b_meas_sel_in)
    |-> ##[1:3] b_irq_flag_out) else $error("measure select change did not set flag");
endmodule
bind mmt_top mmt_chk chk_u (.*);
`default_nettype wire

// file: mmt_top_tb.sv
// Purpose: Self-checking bench for mmt_top
// Assumes: Flags cleared by a clear or an accept pulse, chosen at random
// Notes: Reload reads are short, so they are searched in a bounded window
`timescale 1ns/1ps
`default_nettype none
module mmt_top_tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] a_md = 2'h2;
  logic [1:0] b_md = 2'h0;
  logic a_st = 1'b0, a_up = 1'b0, a_wr = 1'b0, a_pin = 1'b0, a_clr = 1'b0;
  logic b_st = 1'b0, b_sel = 1'b0, b_wr = 1'b0, b_pin = 1'b0, b_clr = 1'b0;
  logic a_ack = 1'b0, b_ack = 1'b0;
  logic [15:0] a_wd = 16'h0000, b_wd = 16'h0000, a_cnt, b_cnt, b_rl, v;
  logic a_o, a_f, b_f, hit;
  int mismatches = 0, comparisons = 0, cyc = 0;
  always #5 mclk = ~mclk;
  mmt_top dut_u (.mclk_in(mclk), .resetn_in(rstn), .a_mode_in(a_md), .a_start_in(a_st), .a_event_up_in(a_up),
    .a_wr_in(a_wr), .a_wdata_in(a_wd), .a_event_pin_in(a_pin), .a_irq_clr_in(a_clr), .a_irq_ack_in(a_ack),
    .a_count_out(a_cnt), .general_timer_output_pin_out(a_o), .a_irq_flag_out(a_f), .b_mode_in(b_md),
    .b_start_in(b_st), .b_meas_sel_in(b_sel), .b_wr_in(b_wr), .b_wdata_in(b_wd), .b_edge_pin_in(b_pin),
    .b_irq_clr_in(b_clr), .b_irq_ack_in(b_ack), .b_count_out(b_cnt), .b_reload_out(b_rl), .b_irq_flag_out(b_f));
  task automatic test_done();
    $display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic nc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(input logic sb, input logic [15:0] d);
    a_wd = d;
    b_wd = d;
    if (sb)
      b_wr = 1'b1;
    else
      a_wr = 1'b1;
    nc(1);
    if (sb)
      b_wr = 1'b0;
    else
      a_wr = 1'b0;
  endtask
  // Accept pulse stands in for the interrupt being taken
  task automatic clr(input logic sb);
    logic k;
    k = 1'($urandom_range(1));
    a_clr = !sb && !k;
    b_clr = sb && !k;
    a_ack = !sb && k;
    b_ack = sb && k;
    nc(1);
    a_clr = 1'b0;
    b_clr = 1'b0;
    a_ack = 1'b0;
    b_ack = 1'b0;
    nc(1);
  endtask
  // Pin held long enough to pass the three-flop synchroniser
  task automatic pulse(input logic sb);
    a_pin = !sb;
    b_pin = sb;
    nc(3);
    a_pin = 1'b0;
    b_pin = 1'b0;
    nc(3);
  endtask
  task automatic watch(input logic sb, input int n, input logic [15:0] w, output logic h);
    h = 1'b0;
    repeat (n)
    begin
      @(negedge mclk);
      if ((sb ? b_cnt : a_cnt) === w)
        h = 1'b1;
    end
  endtask
  function automatic logic [15:0] reload_read(input logic up);
    return up ? 16'h0000 : 16'hFFFF;
  endfunction
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      test_done();
    end
  end
  // --------
  // Sequence
  // --------
  initial
  begin
    void'($urandom(32'h9D7B));
    nc(8);
    rstn = 1'b1;
    nc(6);
    chk({15'h0000, a_f}, 16'h0001);
    a_md = 2'h0;
    nc(3);
    clr(1'b0);
    chk({15'h0000, a_f}, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      v = (i < 2) ? 16'hFFFF : (i < 4) ? 16'h0000 : 16'($urandom);
      wr(i[0], v);
      chk(i[0] ? b_cnt : a_cnt, v);
    end
    for (int i = 0; i < 4; i++)
    begin
      a_md = i[0] ? 2'h1 : 2'h0;
      nc(3);
      clr(1'b0);
      a_md = i[1] ? 2'h3 : 2'h2;
      nc(4);
      chk({15'h0000, a_f}, 16'h0001);
      clr(1'b0);
    end
    a_md = 2'h0;
    wr(1'b0, 16'h0003);
    a_st = 1'b1;
    nc(1);
    chk(a_cnt, 16'h0002);
    watch(1'b0, 12, 16'hFFFF, hit);
    chk({15'h0000, hit}, 16'h0001);
    a_st = 1'b0;
    a_md = 2'h1;
    for (int i = 0; i < 2; i++)
    begin
      a_up = i[0];
      wr(1'b0, i[0] ? 16'hFFFF : 16'h0000);
      a_st = 1'b1;
      fork
        pulse(1'b0);
        watch(1'b0, 10, reload_read(i[0]), hit);
      join
      chk({15'h0000, hit}, 16'h0001);
      a_st = 1'b0;
      nc(1);
    end
    a_md = 2'h2;
    v = 16'h0100 + 16'($urandom_range(255));
    wr(1'b0, v);
    nc(3);
    clr(1'b0);
    a_st = 1'b1;
    nc(4 + $urandom_range(20));
    a_st = 1'b0;
    nc(4);
    chk({15'h0000, a_o}, 16'h0000);
    chk({15'h0000, a_f}, 16'h0001);
    chk(a_cnt, v);
    a_md = 2'h3;
    for (int i = 0; i < 6; i++)
    begin
      wr(1'b0, 16'h0004 + 16'(i));
      a_st = 1'b1;
      nc(3 + $urandom_range(12));
      a_st = 1'b0;
      nc(4);
      chk({15'h0000, a_o}, 16'h0000);
    end
    wr(1'b1, 16'h0002);
    b_st = 1'b1;
    watch(1'b1, 10, 16'hFFFF, hit);
    chk({15'h0000, hit}, 16'h0001);
    b_st = 1'b0;
    b_md = 2'h2;
    nc(2);
    clr(1'b1);
    b_st = 1'b1;
    pulse(1'b1);
    chk(b_rl, mmt_pkg::UNDEF_VAL);
    chk({15'h0000, b_f}, 16'h0000);
    b_sel = 1'b1;
    nc(4);
    chk({15'h0000, b_f}, 16'h0001);
    test_done();
  end
endmodule
`default_nettype wire
